// *** logic/flash_bus_host.sv ***
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
module flash_bus_host
   import flash_host_pkg::*;
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [PADDR_W-1:0]  paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Flash control pins
   output logic [ADDR_W-1:0]        flash_addr,
   output logic                     device_select_n,
   output logic                     output_gate_n,
   output logic                     write_strobe_n,
   output logic                     reset_pin_n,
   output logic                     reset_at_protect_level,
   output logic                     width_select_n,
   output logic                     protect_accel_pin,
   output logic                     protect_accel_boost,
   input  wire logic                busy_indicator_n,
   // Flash data pins
   input  wire logic [DATA_W-2:0]   dq_in,
   output logic [DATA_W-2:0]        dq_out,
   output logic                     dq_oe,
   input  wire logic                top_data_or_low_addr_in,
   output logic                     top_data_or_low_addr_out,
   output logic                     top_data_or_low_addr_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // Software registers

   logic [2:0]        cfg_r,    cfg_nxt;
   logic [ADDR_W:0]   addr_r,   addr_nxt;
   logic [DATA_W-1:0] wdata_r,  wdata_nxt;
   logic [DATA_W-1:0] rdata_r,  rdata_nxt;
   logic [31:0]       prdata_nxt;
   logic              pready_nxt, pslverr_nxt;
   logic              done_r,   done_nxt;
   logic              start_r,  start_nxt;
   logic [2:0]        op_req_r, op_req_nxt;
   logic              busy;
   logic              done_set;
   logic [DATA_W-1:0] rd_capture;
   logic              rd_capture_en;
   logic              access, wr_fire;

   function automatic logic known_offset(input logic [PADDR_W-1:0] a);
      known_offset = (a == OFS_CTRL) || (a == OFS_ADDR) || (a == OFS_WDATA) ||
                     (a == OFS_RDATA) || (a == OFS_STATUS) || (a == OFS_CFG);
   endfunction

   // One wait state; the write lands on the edge that samples pready high
   assign access  = psel & penable & ~pready;
   assign wr_fire = psel & penable & pready & pwrite;

   always_comb begin
      cfg_nxt     = cfg_r;
      addr_nxt    = addr_r;
      wdata_nxt   = wdata_r;
      rdata_nxt   = rd_capture_en ? rd_capture : rdata_r;
      start_nxt   = 1'b0;
      op_req_nxt  = op_req_r;
      pready_nxt  = access;
      pslverr_nxt = access & ~known_offset(paddr);
      prdata_nxt  = prdata;
      if (access) begin
         prdata_nxt = 32'h0000_0000;
         if (paddr == OFS_CTRL) begin
            prdata_nxt = {29'h0000_0000, op_req_r};
         end else if (paddr == OFS_ADDR) begin
            prdata_nxt = {10'h000, addr_r};
         end else if (paddr == OFS_WDATA) begin
            prdata_nxt = {16'h0000, wdata_r};
         end else if (paddr == OFS_RDATA) begin
            prdata_nxt = {16'h0000, rdata_r};
         end else if (paddr == OFS_STATUS) begin
            prdata_nxt = {29'h0000_0000, busy_indicator_n, done_r, busy};
         end else if (paddr == OFS_CFG) begin
            prdata_nxt = {29'h0000_0000, cfg_r};
         end
      end
      // Set wins over a clear in the same cycle
      done_nxt = done_set | done_r;
      if (wr_fire) begin
         if (paddr == OFS_CTRL) begin
            // A start while busy is dropped; software polls STATUS first
            if (!busy) begin
               op_req_nxt = pwdata[2:0];
               start_nxt  = 1'b1;
            end
         end else if (paddr == OFS_ADDR) begin
            addr_nxt = pwdata[ADDR_W:0];
         end else if (paddr == OFS_WDATA) begin
            wdata_nxt = pwdata[DATA_W-1:0];
         end else if (paddr == OFS_STATUS) begin
            if (pwdata[STAT_DONE] && !done_set) begin
               done_nxt = 1'b0;
            end
         end else if (paddr == OFS_CFG) begin
            cfg_nxt = pwdata[2:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_r    <= CFG_RESET;
         addr_r   <= '0;
         wdata_r  <= '0;
         rdata_r  <= '0;
         done_r   <= 1'b0;
         start_r  <= 1'b0;
         op_req_r <= OP_READ;
         prdata   <= 32'h0000_0000;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
      end else begin
         cfg_r    <= cfg_nxt;
         addr_r   <= addr_nxt;
         wdata_r  <= wdata_nxt;
         rdata_r  <= rdata_nxt;
         done_r   <= done_nxt;
         start_r  <= start_nxt;
         op_req_r <= op_req_nxt;
         prdata   <= prdata_nxt;
         pready   <= pready_nxt;
         pslverr  <= pslverr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus cycle sequencer

   logic       tick;
   seq_state_t state_r, state_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [2:0] op_r, op_nxt;
   logic       byte_mode;
   logic       is_write_op;
   logic [ADDR_W-1:0] addr_sel;
   logic       low_addr;

   logic [ADDR_W-1:0] flash_addr_nxt;
   logic       ce_n_nxt, oe_n_nxt, we_n_nxt, rst_n_nxt, prot_lvl_nxt;
   logic       boost_nxt, dq_oe_nxt, top_out_nxt, top_oe_nxt;
   logic [DATA_W-2:0] dq_out_nxt;

   tick_divider #(
      .DIV (TICK_DIV)
   ) u_tick (
      .clk     (clk),
      .sys_rst (sys_rst),
      .tick    (tick)
   );

   assign busy      = (state_r != ST_IDLE) | start_r;
   assign byte_mode = cfg_r[CFG_BYTE];
   assign is_write_op = (op_r == OP_WRITE) || (op_r == OP_ACCEL) ||
                        (op_r == OP_PROTECT) || (op_r == OP_UNPROTECT);

   always_comb begin
      // byte mode shifts the address down by one, bit 0 becomes the extra low bit
      addr_sel = byte_mode ? addr_r[ADDR_W:1] : addr_r[ADDR_W-1:0];
      low_addr = addr_r[0];
      // forced A6/A1/A0 pattern for protect and unprotect
      if ((op_r == OP_PROTECT) || (op_r == OP_UNPROTECT)) begin
         addr_sel[6] = (op_r == OP_UNPROTECT);
         addr_sel[1] = 1'b1;
         addr_sel[0] = 1'b0;
      end
   end

   always_comb begin
      state_nxt      = state_r;
      cnt_nxt        = cnt_r;
      op_nxt         = op_r;
      flash_addr_nxt = flash_addr;
      ce_n_nxt       = device_select_n;
      oe_n_nxt       = output_gate_n;
      we_n_nxt       = write_strobe_n;
      prot_lvl_nxt   = reset_at_protect_level;
      boost_nxt      = protect_accel_boost;
      dq_oe_nxt      = dq_oe;
      dq_out_nxt     = dq_out;
      done_set       = 1'b0;
      rd_capture     = {top_data_or_low_addr_in, dq_in};
      rd_capture_en  = 1'b0;
      // software may hold the device in reset
      rst_n_nxt      = ~cfg_r[CFG_HOLD_RST];
      // word mode while width select is high
      // byte mode drives the lowest address bit on the top data line
      top_oe_nxt     = byte_mode ? 1'b1 : top_data_or_low_addr_oe;
      top_out_nxt    = byte_mode ? low_addr : top_data_or_low_addr_out;
      case (state_r)
         ST_IDLE: begin
            if (start_r) begin
               op_nxt    = op_req_r;
               cnt_nxt   = 8'h00;
               state_nxt = ST_SETUP;
            end
         end
         ST_SETUP: begin
            flash_addr_nxt = addr_sel;
            if (op_r == OP_RESET) begin
               // reset pulse returns the device to array read
               rst_n_nxt = 1'b0;
               cnt_nxt   = 8'h00;
               state_nxt = ST_STROBE;
            end else begin
               ce_n_nxt     = 1'b0;
               // reset pin raised to protect level for sector protection
               prot_lvl_nxt = (op_r == OP_PROTECT) || (op_r == OP_UNPROTECT);
               // boost only around an accelerated program cycle
               boost_nxt    = (op_r == OP_ACCEL);
               if (is_write_op) begin
                  // the top data line only carries program data in word mode
                  dq_out_nxt  = wdata_r[DATA_W-2:0];
                  dq_oe_nxt   = 1'b1;
                  top_out_nxt = byte_mode ? low_addr : wdata_r[DATA_W-1];
                  top_oe_nxt  = 1'b1;
               end else begin
                  dq_oe_nxt  = 1'b0;
                  top_oe_nxt = byte_mode;
               end
               if (tick) begin
                  cnt_nxt = cnt_r + 8'h01;
                  if (cnt_r + 8'h01 >= SETUP_TICKS) begin
                     cnt_nxt = 8'h00;
                     we_n_nxt  = ~is_write_op;
                     oe_n_nxt  = is_write_op;
                     state_nxt = ST_STROBE;
                  end
               end
            end
         end
         ST_STROBE: begin
            if (op_r == OP_RESET) begin
               rst_n_nxt = 1'b0;
            end
            if (tick) begin
               cnt_nxt = cnt_r + 8'h01;
               if (cnt_r + 8'h01 >= ((op_r == OP_RESET) ? RESET_TICKS : STROBE_TICKS)) begin
                  cnt_nxt = 8'h00;
                  if (!is_write_op && (op_r != OP_RESET)) begin
                     rd_capture_en = 1'b1;
                     // byte reads use only the low eight lines
                     if (byte_mode) begin
                        rd_capture = {8'h00, dq_in[7:0]};
                     end
                  end
                  // strobe rises with data still held stable
                  we_n_nxt  = 1'b1;
                  oe_n_nxt  = 1'b1;
                  state_nxt = ST_RECOVER;
               end
            end
         end
         ST_RECOVER: begin
            if (tick) begin
               cnt_nxt = cnt_r + 8'h01;
               if (cnt_r + 8'h01 >= RECOVER_TICKS) begin
                  // select released, device back to standby
                  ce_n_nxt     = 1'b1;
                  dq_oe_nxt    = 1'b0;
                  top_oe_nxt   = byte_mode;
                  prot_lvl_nxt = 1'b0;
                  // boost removed after the accelerated cycle
                  boost_nxt    = 1'b0;
                  done_set     = 1'b1;
                  cnt_nxt      = 8'h00;
                  state_nxt    = ST_IDLE;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r                  <= ST_IDLE;
         cnt_r                    <= 8'h00;
         op_r                     <= OP_READ;
         flash_addr               <= '0;
         device_select_n          <= 1'b1;
         output_gate_n            <= 1'b1;
         write_strobe_n           <= 1'b1;
         reset_pin_n              <= 1'b1;
         reset_at_protect_level   <= 1'b0;
         width_select_n           <= 1'b1;
         protect_accel_pin        <= 1'b0;
         protect_accel_boost      <= 1'b0;
         dq_out                   <= '0;
         dq_oe                    <= 1'b0;
         top_data_or_low_addr_out <= 1'b0;
         top_data_or_low_addr_oe  <= 1'b0;
      end else begin
         state_r                  <= state_nxt;
         cnt_r                    <= cnt_nxt;
         op_r                     <= op_nxt;
         flash_addr               <= flash_addr_nxt;
         device_select_n          <= ce_n_nxt;
         output_gate_n            <= oe_n_nxt;
         write_strobe_n           <= we_n_nxt;
         reset_pin_n              <= rst_n_nxt;
         reset_at_protect_level   <= prot_lvl_nxt;
         width_select_n           <= ~byte_mode;
         // pin low keeps outer boot sectors locked; software picks the level
         protect_accel_pin        <= cfg_r[CFG_WP_HIGH];
         protect_accel_boost      <= boost_nxt;
         dq_out                   <= dq_out_nxt;
         dq_oe                    <= dq_oe_nxt;
         top_data_or_low_addr_out <= top_out_nxt;
         top_data_or_low_addr_oe  <= top_oe_nxt;
      end
   end

endmodule // flash_bus_host

// *** pkg/flash_host_pkg.sv ***
// Functional notes
// - Read needs select and output gate low, write strobe high, address valid.
// - Command write drives write strobe and select low, output gate high.
// - Host applies boost only while accelerated programming, never floats the pin.
// - Protect: reset at protect level, select low, strobe low, A6 low, A1 high.
package flash_host_pkg;

   localparam int          ADDR_W        = 21;
   localparam int          DATA_W        = 16;
   localparam int          PADDR_W       = 8;

   // Register offsets
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_ADDR      = 8'h04;
   localparam logic [7:0]  OFS_WDATA     = 8'h08;
   localparam logic [7:0]  OFS_RDATA     = 8'h0C;
   localparam logic [7:0]  OFS_STATUS    = 8'h10;
   localparam logic [7:0]  OFS_CFG       = 8'h14;

   // Operation codes in CTRL[2:0]
   localparam logic [2:0]  OP_READ       = 3'h0;
   localparam logic [2:0]  OP_WRITE      = 3'h1;
   localparam logic [2:0]  OP_PROTECT    = 3'h2;
   localparam logic [2:0]  OP_UNPROTECT  = 3'h3;
   localparam logic [2:0]  OP_RESET      = 3'h4;
   localparam logic [2:0]  OP_ACCEL      = 3'h5;

   // Field positions
   localparam int          STAT_BUSY     = 0;
   localparam int          STAT_DONE     = 1;
   localparam int          STAT_RDY      = 2;
   localparam int          CFG_BYTE      = 0;
   localparam int          CFG_WP_HIGH   = 1;
   localparam int          CFG_HOLD_RST  = 2;

   // Reset values
   localparam logic [2:0]  CFG_RESET     = 3'h0;

   // Timing
   localparam int          CLK_PERIOD_PS = 5000;
   localparam int          TICK_NS       = 10;
   localparam int          TICK_DIV      = (TICK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          SETUP_NS      = 30;
   localparam int          STROBE_NS     = 120;
   localparam int          RECOVER_NS    = 30;
   localparam int          RESET_NS      = 500;
   localparam logic [7:0]  SETUP_TICKS   = 8'((SETUP_NS + TICK_NS - 1) / TICK_NS);
   localparam logic [7:0]  STROBE_TICKS  = 8'((STROBE_NS + TICK_NS - 1) / TICK_NS);
   localparam logic [7:0]  RECOVER_TICKS = 8'((RECOVER_NS + TICK_NS - 1) / TICK_NS);
   localparam logic [7:0]  RESET_TICKS   = 8'((RESET_NS + TICK_NS - 1) / TICK_NS);

   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER} seq_state_t;

endpackage

// *** logic/tick_divider.sv ***
`timescale 1ns/1ps
module tick_divider #(
   parameter int DIV = 2
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Enable pulse out
   output logic      tick
);

   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic       tick_nxt;

   always_comb begin
      if (cnt_r == 8'(DIV - 1)) begin
         cnt_nxt  = 8'h00;
         tick_nxt = 1'b1;
      end else begin
         cnt_nxt  = cnt_r + 8'h01;
         tick_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_r <= 8'h00;
         tick  <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick  <= tick_nxt;
      end
   end

endmodule // tick_divider

// *** verification/flash_bus_host_properties.sv ***
`timescale 1ns/1ps
module flash_bus_host_checker
   import flash_host_pkg::*;
(
   // Clock and reset
   input wire logic              clk,
   input wire logic              sys_rst,
   // APB
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pready,
   input wire logic              pslverr,
   // Flash pins
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic              device_select_n,
   input wire logic              output_gate_n,
   input wire logic              write_strobe_n,
   input wire logic              reset_pin_n,
   input wire logic              reset_at_protect_level,
   input wire logic              width_select_n,
   input wire logic              protect_accel_boost,
   input wire logic              dq_oe,
   input wire logic              top_data_or_low_addr_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence low_run;
      !write_strobe_n [*8];
   endsequence
   sequence ready_step;
      !pready ##1 pready;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   gate_excl_a: assert property (!(!output_gate_n && !write_strobe_n))
      else $error("read and write strobes low together");
   strobe_sel_a: assert property (!output_gate_n || !write_strobe_n |-> !device_select_n)
      else $error("strobe without select");
   read_float_a: assert property (!output_gate_n |-> !dq_oe)
      else $error("host drives data during read");
   write_drive_a: assert property (!write_strobe_n |-> dq_oe)
      else $error("write strobe without data driven");
   ready_wait_a: assert property ($rose(penable) && psel |-> ready_step)
      else $error("ready not in second access cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   byte_addr_a: assert property (!width_select_n |-> top_data_or_low_addr_oe)
      else $error("low address bit not driven in byte mode");
   prot_addr_a: assert property (reset_at_protect_level && !write_strobe_n |-> flash_addr[1] && !flash_addr[0])
      else $error("protect address bits wrong");
   reset_quiet_a: assert property (!reset_pin_n |-> device_select_n && write_strobe_n && output_gate_n)
      else $error("access during device reset");
   strobe_len_a: assert property ($fell(write_strobe_n) |-> low_run)
      else $error("write strobe too short");
   boost_hold_a: assert property (device_select_n |-> !protect_accel_boost)
      else $error("boost level outside a program cycle");
endmodule // flash_bus_host_checker

bind flash_bus_host flash_bus_host_checker i_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .device_select_n(device_select_n),
   .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n), .reset_pin_n(reset_pin_n),
   .reset_at_protect_level(reset_at_protect_level), .width_select_n(width_select_n),
   .protect_accel_boost(protect_accel_boost), .dq_oe(dq_oe),
   .top_data_or_low_addr_oe(top_data_or_low_addr_oe));

// *** verification/flash_dev_model.sv ***
`timescale 1ns/1ps
module flash_dev_model #(
   parameter logic [7:0] ID_CODE = 8'h5C // Arbitrary value
) (
   // Control pins
   input wire logic [20:0] flash_addr,
   input wire logic        device_select_n,
   input wire logic        output_gate_n,
   input wire logic        write_strobe_n,
   input wire logic        reset_pin_n,
   input wire logic        reset_at_protect_level,
   input wire logic        width_select_n,
   input wire logic        protect_accel_pin,
   input wire logic        protect_accel_boost,
   // Data
   input wire logic [15:0] bus,
   output logic [15:0]     dev_dq,
   output logic            dev_oe,
   output logic            dev_oe_hi,
   output logic            busy_indicator_n
);
   logic [15:0] mem [16];
   logic [15:0] rd_w;
   logic [20:0] lat_a;
   logic        lat_lo;
   logic        id_mode = 1'b0;
   logic        armed = 1'b0;
   logic        last_prot = 1'b0;
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 16'hC3C0 + 16'(i);
      end
   end
   assign busy_indicator_n = 1'b1;
   always @(negedge write_strobe_n or negedge device_select_n) begin
      if (write_strobe_n === 1'b0 && device_select_n === 1'b0) begin
         lat_a = flash_addr;
         lat_lo = bus[15];
      end
   end
   always @(posedge write_strobe_n or posedge device_select_n) begin
      if ((write_strobe_n ^ device_select_n) === 1'b1 && reset_pin_n === 1'b1) begin
         if (reset_at_protect_level) begin
            if (lat_a[1] && !lat_a[0]) last_prot = lat_a[6];
         end else if (armed) begin
            armed = 1'b0;
            // Outermost sector stays locked unless the pin is high or boosted
            if (lat_a[3:0] != 4'hF || protect_accel_pin || protect_accel_boost) begin
               if (width_select_n) mem[lat_a[3:0]] = mem[lat_a[3:0]] & bus;
               else if (lat_lo) mem[lat_a[3:0]][15:8] = mem[lat_a[3:0]][15:8] & bus[7:0];
               else mem[lat_a[3:0]][7:0] = mem[lat_a[3:0]][7:0] & bus[7:0];
            end
         end else begin
            case (bus[7:0])
               8'hA0: armed = 1'b1;
               8'h90: id_mode = 1'b1;
               8'hF0: id_mode = 1'b0;
               // Sector erase shortened to one cycle; the low nibble picks the sector
               8'h30: mem[lat_a[3:0]] = 16'hFFFF;
               default: ;
            endcase
         end
      end
   end
   always @(negedge reset_pin_n) begin
      id_mode = 1'b0;
      armed = 1'b0;
   end
   assign rd_w = id_mode ? {8'h00, ID_CODE} : mem[flash_addr[3:0]];
   assign dev_oe = output_gate_n === 1'b0 && device_select_n === 1'b0 && write_strobe_n === 1'b1 && reset_pin_n === 1'b1;
   assign dev_oe_hi = dev_oe && width_select_n;
   assign dev_dq = width_select_n ? rd_w : {8'h00, bus[15] ? rd_w[15:8] : rd_w[7:0]};
endmodule // flash_dev_model

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench
   import flash_host_pkg::*;
;
   localparam logic [7:0] ID = 8'h5C; // Arbitrary value
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q;
   logic        pready, pslverr, e;
   logic [20:0] flash_addr;
   logic        device_select_n, output_gate_n, write_strobe_n, reset_pin_n, reset_at_protect_level;
   logic        width_select_n, protect_accel_pin, protect_accel_boost, busy_indicator_n;
   logic [14:0] dq_out;
   logic        dq_oe, top_out, top_oe, dev_oe, dev_oe_hi;
   logic [15:0] dev_dq, bus, he, de;
   int          n_mismatch = 0;
   int          checked = 0;
   int          cyc = 0;
   always #2.5 clk = ~clk;
   // Undriven lines wander so a stale value never reads back as valid
   assign he = {top_oe, {15{dq_oe}}};
   assign de = {{8{dev_oe_hi}}, {8{dev_oe}}};
   assign bus = (he & {top_out, dq_out}) | (~he & de & dev_dq) | (~he & ~de & {16{clk}});
   ////////////////////////////////////////////////////////////////////////////
   flash_bus_host i_flash_bus_host (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr),
      .device_select_n(device_select_n), .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n),
      .reset_pin_n(reset_pin_n), .reset_at_protect_level(reset_at_protect_level), .width_select_n(width_select_n),
      .protect_accel_pin(protect_accel_pin), .protect_accel_boost(protect_accel_boost),
      .busy_indicator_n(busy_indicator_n), .dq_in(bus[14:0]), .dq_out(dq_out), .dq_oe(dq_oe),
      .top_data_or_low_addr_in(bus[15]), .top_data_or_low_addr_out(top_out), .top_data_or_low_addr_oe(top_oe));
   flash_dev_model #(.ID_CODE(ID)) i_flash_dev_model (.flash_addr(flash_addr), .device_select_n(device_select_n),
      .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n), .reset_pin_n(reset_pin_n),
      .reset_at_protect_level(reset_at_protect_level), .width_select_n(width_select_n),
      .protect_accel_pin(protect_accel_pin), .protect_accel_boost(protect_accel_boost), .bus(bus),
      .dev_dq(dev_dq), .dev_oe(dev_oe), .dev_oe_hi(dev_oe_hi), .busy_indicator_n(busy_indicator_n));
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Master waits for the answer however long it takes, bounded only by the count
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic op(input logic [2:0] o, input logic [21:0] a, input logic [15:0] d);
      int n;
      n = 0;
      apb(1'b1, OFS_ADDR, {10'h0, a});
      apb(1'b1, OFS_WDATA, {16'h0, d});
      apb(1'b1, OFS_CTRL, {29'h0, o});
      do begin
         apb(1'b0, OFS_STATUS, 32'h0);
         n++;
      end while (q[STAT_BUSY] !== 1'b0 && n < 200);
      chk({31'h0, q[STAT_DONE]}, 32'h1);
      apb(1'b1, OFS_STATUS, 32'h2);
   endtask
   task automatic fr(input logic [21:0] a, input logic [31:0] exp);
      op(OP_READ, a, 16'h0);
      rd(OFS_RDATA, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      rd(OFS_CFG, 32'h0);
      rd(OFS_STATUS, 32'h4);
      rd(8'h18, 32'h0);
      chk({31'h0, e}, 32'h1);
      fr(22'h3, 32'hC3C3); // array read without command
      op(OP_WRITE, 22'h555, 16'hA0); // program command
      op(OP_WRITE, 22'h5, 16'h1234); // second program cycle
      fr(22'h5, 32'h0204); // programmed word
      op(OP_WRITE, 22'h555, 16'h90); // identification entry
      fr(22'h0, {24'h0, ID}); // code on low byte
      op(OP_WRITE, 22'h0, 16'hF0);
      fr(22'h7, 32'hC3C7); // back to array
      op(OP_WRITE, 22'h555, 16'h90);
      op(OP_RESET, 22'h0, 16'h0); // reset pulse
      fr(22'h7, 32'hC3C7); // array after reset
      op(OP_WRITE, 22'h555, 16'h90); // identification again
      apb(1'b1, OFS_CFG, 32'h4);
      rd(OFS_CFG, 32'h4); // software holds reset
      chk({31'h0, reset_pin_n}, 32'h0); // reset pin held low
      apb(1'b1, OFS_CFG, 32'h0);
      fr(22'h7, 32'hC3C7); // array after held reset
      op(OP_WRITE, 22'h555, 16'hA0);
      op(OP_WRITE, 22'hF, 16'h00FF);
      fr(22'hF, 32'hC3CF); // locked outer sector
      apb(1'b1, OFS_CFG, 32'h2);
      rd(OFS_CFG, 32'h2);
      op(OP_WRITE, 22'h555, 16'hA0);
      op(OP_WRITE, 22'hF, 16'hFF0F);
      fr(22'hF, 32'hC30F); // pin high unlocks
      apb(1'b1, OFS_CFG, 32'h0);
      op(OP_ACCEL, 22'h555, 16'hA0); // boosted program
      op(OP_ACCEL, 22'hF, 16'h0000); // boost during program only
      fr(22'hF, 32'h0); // outer sector unlocked
      apb(1'b1, OFS_CFG, 32'h1);
      fr(22'h0B, 32'h02); // high byte by low address bit
      fr(22'h0A, 32'h04); // low byte
      op(OP_WRITE, 22'h555, 16'hA0);
      op(OP_WRITE, 22'h07, 16'h0F); // byte program
      fr(22'h07, 32'h03); // byte lane written
      apb(1'b1, OFS_CFG, 32'h0);
      fr(22'h3, 32'h03C3); // word view of byte write
      op(OP_WRITE, 22'h2, 16'h30); // sector erase
      fr(22'h2, 32'hFFFF); // erased sector reads ones
      op(OP_UNPROTECT, 22'h1000, 16'h0); // unprotect forces A6 high
      chk({31'h0, i_flash_dev_model.last_prot}, 32'h1); // unprotect selected
      op(OP_PROTECT, 22'h1040, 16'h0); // protect forces address bits
      chk({31'h0, i_flash_dev_model.last_prot}, 32'h0); // protect selected
      rd(OFS_STATUS, 32'h4);
      report_and_stop();
   end
endmodule // testbench
